/* hbs_pkg.sv */
// package: register map, fields and timing constants of the brake sequencer
package hbs_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL    = 5'h00; // enable, manual bits
    localparam logic [4:0] OFS_ON_DLY  = 5'h04; // on-delay, cycles
    localparam logic [4:0] OFS_OFF_DLY = 5'h08; // off-delay, cycles
    localparam logic [4:0] OFS_TYPE    = 5'h0C; // brake type
    localparam logic [4:0] OFS_STATUS  = 5'h10; // motor status word
    localparam logic [4:0] OFS_CURRENT = 5'h14; // measured brake current
    localparam logic [4:0] OFS_IRQ     = 5'h18; // sticky events, w1c
    localparam logic [4:0] OFS_MASK    = 5'h1C; // interrupt mask

    // ------------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------------
    localparam int CTL_ENABLE  = 0;
    localparam int CTL_MAN_REL = 1;
    localparam int CTL_MAN_ENG = 2;

    // ------------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------------
    localparam int ST_READY   = 0;
    localparam int ST_BRK_PWR = 1;
    localparam int ST_CUR_ON  = 2;
    localparam int ST_ZERO    = 3;
    localparam int ST_OPEN    = 4;
    localparam int ST_CLOSED  = 5;
    localparam int ST_MANUAL  = 6;

    // ------------------------------------------------------------------
    // event bits
    // ------------------------------------------------------------------
    localparam int EV_OPENED = 0;
    localparam int EV_CLOSED = 1;
    localparam int EV_NUM    = 2;

    // ------------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------------
    localparam int DLY_W = 24;
    localparam int CUR_W = 16;
    localparam logic [DLY_W-1:0] ON_DLY_RST  = 24'h00007D; // 1 us
    localparam logic [DLY_W-1:0] OFF_DLY_RST = 24'h00007D;
    localparam logic [1:0] TYPE_RST = 2'h0;
    // type 0: fail-safe (powered = open), 1: none fitted,
    // 2: inverted (powered = closed)
    localparam logic [1:0] TYPE_FAILSAFE = 2'h0;
    localparam logic [1:0] TYPE_NONE     = 2'h1;
    localparam logic [1:0] TYPE_INVERT   = 2'h2;

    typedef enum logic [6:0] {
        ST_OFF      = 7'h01,
        ST_OPEN_CUR = 7'h02,
        ST_OPEN_BRK = 7'h04,
        ST_ON_WAIT  = 7'h08,
        ST_RUN      = 7'h10,
        ST_CLS_ZERO = 7'h20,
        ST_OFF_WAIT = 7'h40
    } hbs_state_t;
endpackage

/* hbs_sequencer.sv */
// holding brake sequencer with avalon-mm register slave
`timescale 1ns/100ps
module hbs_sequencer
    import hbs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [4:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic [CUR_W-1:0] brake_current_in,
    output logic                  speed_zero_out,
    output logic                  motor_current_on,
    output logic                  brake_power_on,
    output logic                  axis_ready,
    output logic                  irq
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [2:0]        ctrl_ff;
    logic [DLY_W-1:0]  on_dly_ff;
    logic [DLY_W-1:0]  off_dly_ff;
    logic [1:0]        type_ff;
    logic [EV_NUM-1:0] irq_st_ff;
    logic [EV_NUM-1:0] irq_mask_ff;
    logic [CUR_W-1:0]  cur_s1_ff;
    logic [CUR_W-1:0]  cur_s2_ff;
    logic              ack_ff;
    hbs_state_t        state_ff;
    hbs_state_t        nxt_state;
    logic [DLY_W-1:0]  timer_ff;
    logic [DLY_W-1:0]  nxt_timer;
    logic              seq_pwr;
    logic              brake_open_req;
    logic              man_any;
    logic              nxt_brake_pwr;
    logic [EV_NUM-1:0] ev;
    logic              wr_hit;
    logic [31:0]       status_word;

    // one wait state per access: ack pulses in the cycle after the request
    assign wr_hit = avs_write && !ack_ff;

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    // waitrequest is high until ack, so every access takes two edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // writes commit on the edge where waitrequest is sampled low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff     <= 3'h0;
            on_dly_ff   <= ON_DLY_RST;
            off_dly_ff  <= OFF_DLY_RST;
            type_ff     <= TYPE_RST;
            irq_mask_ff <= '0;
        end else if (avs_write && ack_ff && avs_byteenable[0]) begin
            case (avs_address)
                OFS_CTRL:    ctrl_ff <= avs_writedata[2:0];
                OFS_ON_DLY:  on_dly_ff <= avs_writedata[DLY_W-1:0];
                OFS_OFF_DLY: off_dly_ff <= avs_writedata[DLY_W-1:0];
                OFS_TYPE:    type_ff <= avs_writedata[1:0];
                OFS_MASK:    irq_mask_ff <= avs_writedata[EV_NUM-1:0];
                default:     ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // brake current sampling
    // ------------------------------------------------------------------
    // the measurement comes from another domain; two stages before use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_s1_ff <= '0;
            cur_s2_ff <= '0;
        end else begin
            cur_s1_ff <= brake_current_in;
            cur_s2_ff <= cur_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // sequence state machine
    // ------------------------------------------------------------------
    // each step of open and close takes one state, so order is visible
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        case (state_ff)
            ST_OFF: begin
                if (ctrl_ff[CTL_ENABLE]) begin
                    nxt_state = ST_OPEN_CUR;
                end
            end
            ST_OPEN_CUR: begin
                nxt_state = ST_OPEN_BRK;
            end
            ST_OPEN_BRK: begin
                nxt_state = ST_ON_WAIT;
                nxt_timer = on_dly_ff;
            end
            ST_ON_WAIT: begin
                if (!ctrl_ff[CTL_ENABLE]) begin
                    nxt_state = ST_CLS_ZERO;
                end else if (timer_ff <= 24'h000001) begin
                    nxt_state = ST_RUN;
                end else begin
                    nxt_timer = timer_ff - 24'h000001;
                end
            end
            ST_RUN: begin
                if (!ctrl_ff[CTL_ENABLE]) begin
                    nxt_state = ST_CLS_ZERO;
                end
            end
            ST_CLS_ZERO: begin
                nxt_state = ST_OFF_WAIT;
                nxt_timer = off_dly_ff;
            end
            ST_OFF_WAIT: begin
                if (timer_ff <= 24'h000001) begin
                    nxt_state = ST_OFF;
                end else begin
                    nxt_timer = timer_ff - 24'h000001;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_OFF;
            timer_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
        end
    end

    // ------------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------------
    // internal request: brake wanted open from power-up step to close step;
    // decoded from the next state so the registered supply changes on the
    // same edge as the state, one edge after current on, one after zeroing
    assign seq_pwr = (nxt_state == ST_OPEN_BRK) || (nxt_state == ST_ON_WAIT)
                   || (nxt_state == ST_RUN) || (nxt_state == ST_CLS_ZERO);
    assign man_any = ctrl_ff[CTL_MAN_REL] || ctrl_ff[CTL_MAN_ENG];

    // manual bits win over the sequence, engage over release; the
    // override ignores current feed, so a loaded axis may sag
    always_comb begin
        if (ctrl_ff[CTL_MAN_ENG]) begin
            brake_open_req = 1'b0;
        end else if (ctrl_ff[CTL_MAN_REL]) begin
            brake_open_req = 1'b1;
        end else begin
            brake_open_req = seq_pwr;
        end
    end

    // type maps the wanted brake position to supply polarity
    always_comb begin
        case (type_ff)
            TYPE_NONE:   nxt_brake_pwr = 1'b0;
            TYPE_INVERT: nxt_brake_pwr = !brake_open_req;
            default:     nxt_brake_pwr = brake_open_req;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            speed_zero_out   <= 1'b1;
            motor_current_on <= 1'b0;
            brake_power_on   <= 1'b0;
            axis_ready       <= 1'b0;
        end else begin
            // speed held at zero everywhere except ready operation
            speed_zero_out   <= (nxt_state != ST_RUN);
            motor_current_on <= (nxt_state != ST_OFF);
            brake_power_on   <= nxt_brake_pwr;
            axis_ready       <= (nxt_state == ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------------
    assign ev[EV_OPENED] = (state_ff == ST_ON_WAIT) && (nxt_state == ST_RUN);
    assign ev[EV_CLOSED] = (state_ff == ST_OFF_WAIT) && (nxt_state == ST_OFF);

    // a new event in the clearing cycle stays set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_st_ff <= '0;
        end else if (avs_write && ack_ff && avs_address == OFS_IRQ) begin
            irq_st_ff <= (irq_st_ff & ~avs_writedata[EV_NUM-1:0]) | ev;
        end else begin
            irq_st_ff <= irq_st_ff | ev;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_st_ff & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_READY]   = axis_ready;
        status_word[ST_BRK_PWR] = brake_power_on;
        status_word[ST_CUR_ON]  = motor_current_on;
        status_word[ST_ZERO]    = speed_zero_out;
        status_word[ST_OPEN]    = (state_ff == ST_RUN);
        status_word[ST_CLOSED]  = (state_ff == ST_OFF);
        status_word[ST_MANUAL]  = man_any;
    end

    // data is registered together with the ack; unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            case (avs_address)
                OFS_CTRL:    avs_readdata <= {29'h0, ctrl_ff};
                OFS_ON_DLY:  avs_readdata <= {8'h00, on_dly_ff};
                OFS_OFF_DLY: avs_readdata <= {8'h00, off_dly_ff};
                OFS_TYPE:    avs_readdata <= {30'h0, type_ff};
                OFS_STATUS:  avs_readdata <= status_word;
                OFS_CURRENT: avs_readdata <= {16'h0000, cur_s2_ff};
                OFS_IRQ:     avs_readdata <= {30'h0, irq_st_ff};
                OFS_MASK:    avs_readdata <= {30'h0, irq_mask_ff};
                default:     avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // unused write lanes above byte 0 are not decoded
    logic unused_wr;
    assign unused_wr = wr_hit;
endmodule

/* hbs_brake_model.sv */
// behavioural brake coil and power stage facing the sequencer
`timescale 1ns/100ps
module hbs_brake_model
    import hbs_pkg::*;
#(
    parameter logic [CUR_W-1:0] CUR_NOM = 16'h0ABC
)(
    clk,
    brake_power_on,
    brake_current_in
);
    input  wire logic             clk;
    input  wire logic             brake_power_on;
    output logic      [CUR_W-1:0] brake_current_in;
    // coil current trails the supply by a cycle, as a real coil lags
    always_ff @(posedge clk) begin
        brake_current_in <= brake_power_on ? CUR_NOM : 16'h0000;
    end
endmodule

/* hbs_sequencer_chk.sv */
// assertion checker for the holding brake sequencer ports
`timescale 1ns/100ps
module hbs_sequencer_chk
    import hbs_pkg::*;
(
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic [4:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [3:0]       avs_byteenable,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input wire logic [CUR_W-1:0] brake_current_in,
    input wire logic             speed_zero_out,
    input wire logic             motor_current_on,
    input wire logic             brake_power_on,
    input wire logic             axis_ready,
    input wire logic             irq
);
    // ------------------------------------------------------------------
    // sequence and bus checks, all on the one clock
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_open_first;
        $rose(motor_current_on) |-> speed_zero_out && !axis_ready;
    endproperty
    a_open_first: assert property (p_open_first)
        else $error("current came on without zero speed");
    // ready needs current on as it rises and two cycles before it
    property p_ready_cause;
        $rose(axis_ready) |-> motor_current_on && !speed_zero_out
            && $past(speed_zero_out) && $past(motor_current_on, 2);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without a standstill wait");
    property p_ready_cur;
        axis_ready |-> motor_current_on;
    endproperty
    a_ready_cur: assert property (p_ready_cur)
        else $error("ready while current off");
    property p_close_first;
        $fell(axis_ready) |-> speed_zero_out && motor_current_on;
    endproperty
    a_close_first: assert property (p_close_first)
        else $error("ready dropped without zero setpoint");
    property p_off_hold;
        $fell(axis_ready) |=> motor_current_on;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("current cut before the off delay");
    property p_off_bound;
        $fell(axis_ready) |-> ##[1:400] !motor_current_on;
    endproperty
    a_off_bound: assert property (p_off_bound)
        else $error("current never cut after closing");
    property p_cur_off;
        $fell(motor_current_on) |-> speed_zero_out && !axis_ready;
    endproperty
    a_cur_off: assert property (p_cur_off)
        else $error("current cut while axis ready");
    // the slave must answer on the edge right after the request
    property p_wr_ans;
        $rose(avs_write) |=> !avs_waitrequest;
    endproperty
    a_wr_ans: assert property (p_wr_ans)
        else $error("write not answered in one cycle");
    property p_rd_ans;
        $rose(avs_read) |=> !avs_waitrequest;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read not answered in one cycle");
endmodule

bind hbs_sequencer hbs_sequencer_chk i_chk (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .brake_current_in(brake_current_in), .speed_zero_out(speed_zero_out),
    .motor_current_on(motor_current_on), .brake_power_on(brake_power_on),
    .axis_ready(axis_ready), .irq(irq)
);

/* hbs_sequencer_tb.sv */
// self-checking testbench for the holding brake sequencer
`timescale 1ns/100ps
module hbs_sequencer_tb;
    import hbs_pkg::*;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic [4:0]       avs_address = 5'h00;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0;
    logic [3:0]       avs_byteenable = 4'h0;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic [CUR_W-1:0] brake_current_in;
    logic             speed_zero_out, motor_current_on;
    logic             brake_power_on, axis_ready, irq;
    logic [31:0]      rdata;
    int               n, fails = 0, checks_done = 0;
    logic [2:0]       man [4] = '{3'h2, 3'h6, 3'h4, 3'h0};
    logic             man_brk [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    wire  [4:0]       obs = {irq, axis_ready, brake_power_on,
                             motor_current_on, speed_zero_out};

    always #4 clk = ~clk;

    hbs_sequencer i_dut (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .brake_current_in(brake_current_in),
        .speed_zero_out(speed_zero_out),
        .motor_current_on(motor_current_on),
        .brake_power_on(brake_power_on), .axis_ready(axis_ready), .irq(irq)
    );
    hbs_brake_model i_brake (
        .clk(clk), .brake_power_on(brake_power_on),
        .brake_current_in(brake_current_in)
    );

    // ------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one access; starts on a rising edge so a wait never races it
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= w;
        avs_read       <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input string nm);
        bus(1'b0, a, 32'h0, 4'h0);
        chk(nm, rdata, e);
    endtask
    // outputs are polled on the falling edge where they have settled
    task automatic wt(input int b, input logic lv, output int k);
        k = 0;
        while (obs[b] !== lv && k < 400) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under ten thousand cycles
    initial begin
        #400000;
        fails++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("idle outputs", obs, 5'b00001);
        rd(OFS_ON_DLY, ON_DLY_RST, "on delay reset");
        rd(OFS_OFF_DLY, OFF_DLY_RST, "off delay reset");
        rd(OFS_TYPE, TYPE_RST, "type reset");
        rd(OFS_MASK, 32'h0, "mask reset");
        rd(5'h03, 32'h0, "unmapped read");
        bus(1'b1, OFS_ON_DLY, 32'h10, 4'h0);
        rd(OFS_ON_DLY, ON_DLY_RST, "byteenable off write");
        $display("test reset done");
        bus(1'b1, OFS_ON_DLY, 32'h5, 4'hF);
        bus(1'b1, OFS_OFF_DLY, 32'h4, 4'hF);
        bus(1'b1, OFS_MASK, 32'h3, 4'hF);
        bus(1'b1, OFS_CTRL, 32'h1, 4'hF);
        wt(1, 1'b1, n);
        chk("open step 1", obs, 5'b00011);
        @(negedge clk);
        chk("open step 2", obs, 5'b00111);
        wt(3, 1'b1, n);
        chk("on delay", n >= 5 && n <= 7, 1'b1);
        chk("opened", obs[3:0], 4'b1110);
        rd(OFS_STATUS, 32'h17, "status open");
        rd(OFS_CURRENT, 32'h0ABC, "brake current");
        rd(OFS_IRQ, 32'h1, "event opened");
        chk("irq opened", obs[4], 1'b1);
        bus(1'b1, OFS_IRQ, 32'h1, 4'h0);
        bus(1'b1, OFS_CTRL, 32'h5, 4'hF);
        repeat (3) @(negedge clk);
        chk("engage in run", obs[4:2], 3'b010);
        bus(1'b1, OFS_CTRL, 32'h1, 4'hF);
        repeat (3) @(negedge clk);
        chk("back to internal", obs[3:2], 2'b11);
        $display("test open done");
        bus(1'b1, OFS_CTRL, 32'h0, 4'hF);
        wt(3, 1'b0, n);
        chk("close step 1", obs[3:0], 4'b0111);
        @(negedge clk);
        chk("close step 2", obs[3:0], 4'b0011);
        wt(1, 1'b0, n);
        chk("off delay", n >= 4 && n <= 6, 1'b1);
        chk("closed", obs[3:0], 4'b0001);
        rd(OFS_IRQ, 32'h2, "event closed");
        chk("irq closed", obs[4], 1'b1);
        bus(1'b1, OFS_IRQ, 32'h3, 4'hF);
        $display("test close done");
        foreach (man[i]) begin
            bus(1'b1, OFS_CTRL, {29'h0, man[i]}, 4'hF);
            repeat (3) @(negedge clk);
            chk("manual", obs[2:1], {man_brk[i], 1'b0});
        end
        $display("test manual done");
        bus(1'b1, OFS_MASK, 32'h0, 4'hF);
        for (int t = 1; t <= 2; t++) begin
            bus(1'b1, OFS_TYPE, 32'(t), 4'hF);
            bus(1'b1, OFS_CTRL, 32'h1, 4'hF);
            wt(3, 1'b1, n);
            chk("typed brake", obs[2], 1'b0);
            bus(1'b1, OFS_CTRL, 32'h0, 4'hF);
            wt(1, 1'b0, n);
        end
        rd(OFS_IRQ, 32'h3, "masked events");
        chk("irq masked", obs[4], 1'b0);
        bus(1'b1, OFS_MASK, 32'h3, 4'hF);
        repeat (3) @(negedge clk);
        chk("irq unmasked", obs[4], 1'b1);
        bus(1'b1, OFS_IRQ, 32'h3, 4'hF);
        repeat (3) @(negedge clk);
        chk("irq cleared", obs[4], 1'b0);
        $display("test type and irq done");
        give_verdict();
    end
endmodule
